//--- fdsr_pkg.sv
package fdsr_pkg;

    // Register offsets
    localparam logic [7:0] FDSR_OFF_POLARITY = 8'h09;
    localparam logic [7:0] FDSR_OFF_FAULT_FLAGS_PRIMARY = 8'h0a;
    localparam logic [7:0] FDSR_OFF_FAULT_FLAGS_SECONDARY = 8'h0b;
    localparam logic [7:0] FDSR_OFF_IDENT = 8'h0c;
    localparam logic [7:0] FDSR_OFF_LAST_FLASH = 8'h0d;

    // Field positions
    localparam int FDSR_POL_BIT = 6;
    localparam int FDSR_ID_LSB = 3;
    localparam int FDSR_REV_LSB = 0;
    localparam int FDSR_FL1_W = 8;
    localparam int FDSR_FL2_W = 5;
    localparam int FDSR_CODE_W = 7;
    localparam int FDSR_CURRENT_SHIFT = 7;

    // Reset values
    localparam logic FDSR_POL_RST = 1'b0;
    localparam logic [6:0] FDSR_CODE_RST = 7'h7f;
    localparam logic [7:0] FDSR_BYTE_RST = 8'h00;
    localparam logic [2:0] FDSR_CNT_RST = 3'h0;

    // Primary fault events, msb first as stored in the register
    typedef struct packed {
        logic tx_sync;
        logic out_short;
        logic led_one_output_short;
        logic led_two_output_short;
        logic current_limit;
        logic thermal_shutdown;
        logic undervoltage_lockout;
        logic flash_timeout;
    } fdsr_evt1_s;

    // Secondary fault events, msb first
    typedef struct packed {
        logic thermistor_short;
        logic thermistor_open;
        logic low_input_flash_monitor_trip;
        logic overvoltage_protection;
        logic temp_trip;
    } fdsr_evt2_s;

    // Code reported by the low input flash monitor
    typedef struct packed {
        logic valid;
        logic [6:0] code;
    } fdsr_code_s;

    typedef enum logic [2:0] {
        FDSR_IDLE,
        FDSR_ADDR,
        FDSR_ACK_ADDR,
        FDSR_WR_BYTE,
        FDSR_ACK_WR,
        FDSR_RD_BYTE,
        FDSR_RD_ACK
    } fdsr_state_e;

endpackage : fdsr_pkg

//--- fdsr_sticky_flags.sv
`timescale 1ns/1ps
module fdsr_sticky_flags
    import fdsr_pkg::*;
#(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Events and clear
    input wire logic [W-1:0] evt_in,
    input wire logic clr_in,
    // Latched flags
    output logic [W-1:0] flags_out
);

    logic [W-1:0] flags_r;
    logic [W-1:0] flags_nxt;

    // Set wins over clear-on-read
    always_comb begin
        flags_nxt = (clr_in ? '0 : flags_r) | evt_in;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign flags_out = flags_r;

    a_flag_sticky_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (!clr_in && (flags_r != '0)) |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
        else $error("flag dropped without a read");

    a_flag_event_set: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (evt_in != '0) |=> ((flags_r & $past(evt_in)) == $past(evt_in)))
        else $error("event not latched");

endmodule : fdsr_sticky_flags

//--- fdsr_status_regs.sv
`timescale 1ns/1ps
// Operation
// - While the driver is active, torch polarity writes are ignored and polarity holds.
// - Register 0x0a holds eight primary fault and event flags, bit 7 to 0.
// - Register 0x0b holds five secondary flags in bits 4 to 0, upper bits zero.
// - Register 0x0c holds identity in bits 5:3 and revision in bits 2:0.
// - Register 0x0d holds the latest monitor current code in bits 6:0.
// - LED current equals target times code plus one, divided by 128.
module fdsr_status_regs
    import fdsr_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = 7'h2a,
    parameter logic [2:0] IDENTITY_AND_REVISION = 3'h5, // Arbitrary value
    parameter logic [2:0] SILICON_REV = 3'h3, // Arbitrary value
    parameter int TGT_W = 11
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Driver state and events
    input wire logic driver_active_in,
    input wire fdsr_evt1_s evt1_in,
    input wire fdsr_evt2_s evt2_in,
    input wire fdsr_code_s monitor_in,
    input wire logic [TGT_W-1:0] flash_target_in,
    // Block outputs
    output logic torch_polarity_out,
    output logic [FDSR_CODE_W-1:0] last_code_out,
    output logic [TGT_W-1:0] led_current_out
);

    // Pin synchronisers; stage two and its delayed copy feed the logic
    logic [2:0] scl_sync_r;
    logic [2:0] sda_sync_r;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            scl_sync_r <= 3'h7;
            sda_sync_r <= 3'h7;
        end else begin
            scl_sync_r <= {scl_sync_r[1:0], scl_in};
            sda_sync_r <= {sda_sync_r[1:0], sda_in};
        end
    end

    always_comb begin
        scl_rise = scl_sync_r[1] && !scl_sync_r[2];
        scl_fall = !scl_sync_r[1] && scl_sync_r[2];
        bus_start = scl_sync_r[1] && scl_sync_r[2] && !sda_sync_r[1] && sda_sync_r[2];
        bus_stop = scl_sync_r[1] && scl_sync_r[2] && sda_sync_r[1] && !sda_sync_r[2];
    end

    // Flag banks
    logic [FDSR_FL1_W-1:0] fault_flags_primary;
    logic [FDSR_FL2_W-1:0] fault_flags_secondary;
    logic clr1;
    logic clr2;

    fdsr_sticky_flags #(.W(FDSR_FL1_W)) u_fault_flags_primary (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .evt_in(evt1_in),
        .clr_in(clr1),
        .flags_out(fault_flags_primary)
    );

    fdsr_sticky_flags #(.W(FDSR_FL2_W)) u_fault_flags_secondary (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .evt_in(evt2_in),
        .clr_in(clr2),
        .flags_out(fault_flags_secondary)
    );

    // Status and control state
    logic torch_pol_r;
    logic torch_pol_nxt;
    logic [FDSR_CODE_W-1:0] last_code_r;
    logic [FDSR_CODE_W-1:0] last_code_nxt;
    logic [TGT_W-1:0] led_current_r;
    logic [TGT_W-1:0] led_current_nxt;

    function automatic logic [7:0] read_byte(input logic [7:0] ptr, input logic [7:0] f1,
                                             input logic [4:0] f2, input logic pol,
                                             input logic [6:0] code);
        logic [7:0] d;
        d = FDSR_BYTE_RST;
        case (ptr)
            FDSR_OFF_POLARITY: d[FDSR_POL_BIT] = pol;
            FDSR_OFF_FAULT_FLAGS_PRIMARY: d = f1;
            FDSR_OFF_FAULT_FLAGS_SECONDARY: d = {3'h0, f2};
            FDSR_OFF_IDENT: d = {2'h0, IDENTITY_AND_REVISION, SILICON_REV};
            FDSR_OFF_LAST_FLASH: d = {1'b0, code};
            default: d = FDSR_BYTE_RST;
        endcase
        return d;
    endfunction : read_byte

    function automatic logic [TGT_W-1:0] led_current(input logic [TGT_W-1:0] tgt,
                                                     input logic [6:0] code);
        logic [TGT_W+7:0] prod;
        prod = {8'h00, tgt} * ({{TGT_W{1'b0}}, 1'b0, code} + {{(TGT_W+7){1'b0}}, 1'b1});
        return prod[TGT_W+FDSR_CURRENT_SHIFT-1:FDSR_CURRENT_SHIFT];
    endfunction : led_current

    // Serial slave state
    fdsr_state_e state_r;
    fdsr_state_e state_nxt;
    logic [2:0] bit_cnt_r;
    logic [2:0] bit_cnt_nxt;
    logic [7:0] shreg_r;
    logic [7:0] shreg_nxt;
    logic [7:0] ptr_r;
    logic [7:0] ptr_nxt;
    logic rw_r;
    logic rw_nxt;
    logic first_r;
    logic first_nxt;
    logic nack_r;
    logic nack_nxt;
    logic sda_oe_r;
    logic sda_oe_nxt;
    logic wr_pulse;
    logic [7:0] load_byte;
    logic load_rd;

    always_comb begin
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        shreg_nxt = shreg_r;
        ptr_nxt = ptr_r;
        rw_nxt = rw_r;
        first_nxt = first_r;
        nack_nxt = nack_r;
        sda_oe_nxt = sda_oe_r;
        wr_pulse = 1'b0;
        load_rd = 1'b0;
        load_byte = read_byte(ptr_r, fault_flags_primary, fault_flags_secondary, torch_pol_r, last_code_r);
        if (bus_stop) begin
            state_nxt = FDSR_IDLE;
            nack_nxt = 1'b0;
            sda_oe_nxt = 1'b0;
        end else if (bus_start) begin
            // Drop a master NACK left from a read, else the first fall acts as byte end
            state_nxt = FDSR_ADDR;
            bit_cnt_nxt = FDSR_CNT_RST;
            nack_nxt = 1'b0;
            sda_oe_nxt = 1'b0;
        end else begin
            case (state_r)
                FDSR_IDLE: begin
                    sda_oe_nxt = 1'b0;
                end
                FDSR_ADDR, FDSR_WR_BYTE: begin
                    if (scl_rise) begin
                        shreg_nxt = {shreg_r[6:0], sda_sync_r[1]};
                        bit_cnt_nxt = bit_cnt_r + 3'h1;
                        if (bit_cnt_r == 3'h7) begin
                            if (state_r == FDSR_WR_BYTE) begin
                                wr_pulse = 1'b1;
                            end
                        end
                    end
                end
                FDSR_ACK_ADDR: begin
                    if (scl_fall) begin
                        bit_cnt_nxt = FDSR_CNT_RST;
                        if (rw_r) begin
                            load_rd = 1'b1;
                            shreg_nxt = load_byte;
                            sda_oe_nxt = !load_byte[7];
                            state_nxt = FDSR_RD_BYTE;
                        end else begin
                            sda_oe_nxt = 1'b0;
                            first_nxt = 1'b1;
                            state_nxt = FDSR_WR_BYTE;
                        end
                    end
                end
                FDSR_ACK_WR: begin
                    if (scl_fall) begin
                        sda_oe_nxt = 1'b0;
                        bit_cnt_nxt = FDSR_CNT_RST;
                        state_nxt = FDSR_WR_BYTE;
                    end
                end
                FDSR_RD_BYTE: begin
                    if (scl_fall) begin
                        bit_cnt_nxt = bit_cnt_r + 3'h1;
                        shreg_nxt = {shreg_r[6:0], 1'b0};
                        sda_oe_nxt = !shreg_r[6];
                        if (bit_cnt_r == 3'h7) begin
                            sda_oe_nxt = 1'b0;
                            ptr_nxt = ptr_r + 8'h01;
                            state_nxt = FDSR_RD_ACK;
                        end
                    end
                end
                FDSR_RD_ACK: begin
                    if (scl_rise) begin
                        nack_nxt = sda_sync_r[1];
                    end else if (scl_fall) begin
                        if (nack_r) begin
                            state_nxt = FDSR_IDLE;
                        end else begin
                            load_rd = 1'b1;
                            shreg_nxt = load_byte;
                            sda_oe_nxt = !load_byte[7];
                            state_nxt = FDSR_RD_BYTE;
                        end
                    end
                end
                default: begin
                    state_nxt = FDSR_IDLE;
                    sda_oe_nxt = 1'b0;
                end
            endcase
            // Eighth clock fall after a full byte: acknowledge or drop
            if ((state_r == FDSR_ADDR || state_r == FDSR_WR_BYTE) && scl_fall
                    && bit_cnt_r == FDSR_CNT_RST && !first_r && state_r == FDSR_WR_BYTE) begin
                state_nxt = FDSR_ACK_WR;
                sda_oe_nxt = 1'b1;
            end
            if (state_r == FDSR_ADDR && scl_fall && bit_cnt_r == FDSR_CNT_RST && nack_r) begin
                if (shreg_r[7:1] == SLAVE_ADDR) begin
                    rw_nxt = shreg_r[0];
                    sda_oe_nxt = 1'b1;
                    state_nxt = FDSR_ACK_ADDR;
                end else begin
                    state_nxt = FDSR_IDLE;
                end
            end
            if (state_r == FDSR_WR_BYTE && scl_fall && bit_cnt_r == FDSR_CNT_RST && first_r
                    && nack_r) begin
                state_nxt = FDSR_ACK_WR;
                sda_oe_nxt = 1'b1;
            end
        end
        // Byte-complete marker: nack_r doubles as a full-byte tag in write phases
        if (state_r == FDSR_ADDR || state_r == FDSR_WR_BYTE) begin
            if (bus_start || bus_stop) begin
                nack_nxt = 1'b0;
            end else if (scl_rise) begin
                nack_nxt = (bit_cnt_r == 3'h7);
            end else if (scl_fall && bit_cnt_r == FDSR_CNT_RST) begin
                nack_nxt = 1'b0;
            end
        end
        if (wr_pulse) begin
            if (first_r) begin
                ptr_nxt = {shreg_r[6:0], sda_sync_r[1]};
                first_nxt = 1'b0;
            end else begin
                ptr_nxt = ptr_r + 8'h01;
            end
        end
    end

    // Clear-on-read when a flag byte is loaded for shifting
    always_comb begin
        clr1 = load_rd && (ptr_r == FDSR_OFF_FAULT_FLAGS_PRIMARY);
        clr2 = load_rd && (ptr_r == FDSR_OFF_FAULT_FLAGS_SECONDARY);
    end

    always_comb begin
        torch_pol_nxt = torch_pol_r;
        if (wr_pulse && !first_r && ptr_r == FDSR_OFF_POLARITY && !driver_active_in) begin
            torch_pol_nxt = shreg_r[FDSR_POL_BIT - 1];
        end
        last_code_nxt = monitor_in.valid ? monitor_in.code : last_code_r;
        led_current_nxt = led_current(flash_target_in, last_code_r);
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_r <= FDSR_IDLE;
            bit_cnt_r <= FDSR_CNT_RST;
            shreg_r <= FDSR_BYTE_RST;
            ptr_r <= FDSR_BYTE_RST;
            rw_r <= 1'b0;
            first_r <= 1'b0;
            nack_r <= 1'b0;
            sda_oe_r <= 1'b0;
            torch_pol_r <= FDSR_POL_RST;
            last_code_r <= FDSR_CODE_RST;
            led_current_r <= '0;
        end else begin
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shreg_r <= shreg_nxt;
            ptr_r <= ptr_nxt;
            rw_r <= rw_nxt;
            first_r <= first_nxt;
            nack_r <= nack_nxt;
            sda_oe_r <= sda_oe_nxt;
            torch_pol_r <= torch_pol_nxt;
            last_code_r <= last_code_nxt;
            led_current_r <= led_current_nxt;
        end
    end

    // Open-drain: the line is only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe_out = sda_oe_r;
    assign torch_polarity_out = torch_pol_r;
    assign last_code_out = last_code_r;
    assign led_current_out = led_current_r;

    a_polarity_frozen: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        driver_active_in |=> $stable(torch_pol_r))
        else $error("torch polarity changed while driver active");

    a_fault_flags_primary_txsync: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        evt1_in.tx_sync |=> fault_flags_primary[7])
        else $error("tx sync event missing from flag bit 7");

    a_fault_flags_secondary_layout: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        evt2_in.thermistor_short |=> fault_flags_secondary[4])
        else $error("secondary flag layout wrong");

    a_ident_fields: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        load_rd && ptr_r == FDSR_OFF_IDENT |=> (shreg_r == {2'h0, IDENTITY_AND_REVISION, SILICON_REV}))
        else $error("identity byte wrong");

    a_last_code_track: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        monitor_in.valid |=> (last_code_r == $past(monitor_in.code)))
        else $error("last flash code not updated");

    a_current_scale: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (last_code_r == FDSR_CODE_RST) ##1 $stable(flash_target_in) && $stable(last_code_r)
            |=> (led_current_r == $past(flash_target_in, 2)))
        else $error("full scale code does not give target current");

endmodule : fdsr_status_regs

//--- fdsr_host_model.sv
`timescale 1ns/1ps
module fdsr_host_model (
    // Clock
    input wire logic clk_in,
    // Serial bus
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_in);
    endtask : wait_clk

    // Data moves only while clock is low, well clear of its edges
    task automatic bit_io(input logic b, output logic r);
        wait_clk(2);
        sda_out = b;
        wait_clk(4);
        scl_out = 1'b1;
        wait_clk(4);
        r = sda_in;
        scl_out = 1'b0;
    endtask : bit_io

    // Also serves as repeated start
    task automatic start_cond();
        wait_clk(2);
        sda_out = 1'b1;
        wait_clk(4);
        scl_out = 1'b1;
        wait_clk(4);
        sda_out = 1'b0;
        wait_clk(4);
        scl_out = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        wait_clk(2);
        sda_out = 1'b0;
        wait_clk(4);
        scl_out = 1'b1;
        wait_clk(4);
        sda_out = 1'b1;
        wait_clk(4);
    endtask : stop_cond

    task automatic tx_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask : tx_byte

    task automatic rx_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nack, r);
    endtask : rx_byte
endmodule : fdsr_host_model

//--- fdsr_status_regs_test.sv
`timescale 1ns/1ps
module fdsr_status_regs_test;
    import fdsr_pkg::*;
    localparam logic [6:0] DEV_ADDR = 7'h2a;
    localparam logic [2:0] ID_CODE = 3'h5; // Arbitrary value
    localparam logic [2:0] REV_CODE = 3'h3; // Arbitrary value
    logic clk, rst, act, scl, host_sda, sda_line, sda_o, sda_oe, pol;
    fdsr_evt1_s evt1;
    fdsr_evt2_s evt2;
    fdsr_code_s mon;
    logic [10:0] tgt, led_cur;
    logic [6:0] last_code;
    logic [7:0] d0, d1;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;

    // Open-drain wire with pull-up
    assign sda_line = host_sda & ~(sda_oe & ~sda_o);

    fdsr_status_regs #(.SLAVE_ADDR(DEV_ADDR), .IDENTITY_AND_REVISION(ID_CODE), .SILICON_REV(REV_CODE),
        .TGT_W(11)) dut (.ref_clk_in(clk), .rst_in(rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .driver_active_in(act), .evt1_in(evt1),
        .evt2_in(evt2), .monitor_in(mon), .flash_target_in(tgt), .torch_polarity_out(pol),
        .last_code_out(last_code), .led_current_out(led_cur));

    fdsr_host_model host (.clk_in(clk), .sda_in(sda_line), .scl_out(scl), .sda_out(host_sda));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("ERROR run_length expected done seen timeout");
            wrap_up();
        end
    end

    task automatic tx(input logic [7:0] b, input logic exp_ack);
        logic ack;
        host.tx_byte(b, ack);
        check("ack", 16'(exp_ack), 16'(ack));
    endtask : tx

    task automatic wr_reg(input logic [7:0] off, input logic [7:0] d);
        host.start_cond();
        tx({DEV_ADDR, 1'b0}, 1'b1);
        tx(off, 1'b1);
        tx(d, 1'b1);
        host.stop_cond();
    endtask : wr_reg

    // Reads two bytes from off with auto-increment
    task automatic rd_reg(input logic [7:0] off, output logic [7:0] r0, output logic [7:0] r1);
        host.start_cond();
        tx({DEV_ADDR, 1'b0}, 1'b1);
        tx(off, 1'b1);
        host.start_cond();
        tx({DEV_ADDR, 1'b1}, 1'b1);
        host.rx_byte(1'b0, r0);
        host.rx_byte(1'b1, r1);
        host.stop_cond();
    endtask : rd_reg

    task automatic test_ident();
        rd_reg(FDSR_OFF_IDENT, d0, d1);
        check("ident", {8'h00, 2'b00, ID_CODE, REV_CODE}, d0);
        check("last_flash_reset", 16'h007f, d1);
        host.start_cond();
        tx({DEV_ADDR ^ 7'h01, 1'b0}, 1'b0);
        host.stop_cond();
        rd_reg(8'h20, d0, d1);
        check("unmapped", 16'h0000, {d1, d0});
    endtask : test_ident

    task automatic test_flags(input logic [7:0] p1, input logic [4:0] p2);
        evt1 = fdsr_evt1_s'(p1);
        evt2 = fdsr_evt2_s'(p2);
        @(negedge clk);
        evt1 = '0;
        evt2 = '0;
        rd_reg(FDSR_OFF_FAULT_FLAGS_SECONDARY, d0, d1);
        check("fault_flags_secondary", {8'h00, 3'b000, p2}, d0);
        rd_reg(FDSR_OFF_FAULT_FLAGS_PRIMARY, d0, d1);
        check("fault_flags_primary", {8'h00, p1}, d0);
        check("fault_flags_secondary_cleared", 16'h0000, d1);
        rd_reg(FDSR_OFF_FAULT_FLAGS_PRIMARY, d0, d1);
        check("fault_flags_primary_cleared", 16'h0000, d0);
    endtask : test_flags

    task automatic test_code(input logic [6:0] c);
        logic [31:0] exp_cur;
        mon = {1'b1, c};
        @(negedge clk);
        mon = {1'b0, ~c};
        repeat (2) @(negedge clk);
        exp_cur = (32'(tgt) * (32'(c) + 32'd1)) >> 7;
        check("last_code", 16'(c), 16'(last_code));
        check("led_current", exp_cur[15:0], 16'(led_cur));
        rd_reg(FDSR_OFF_LAST_FLASH, d0, d1);
        check("last_flash_reg", {8'h00, 1'b0, c}, d0);
    endtask : test_code

    task automatic test_polarity();
        wr_reg(FDSR_OFF_POLARITY, 8'h40);
        check("pol_set", 16'h0001, 16'(pol));
        act = 1'b1;
        wr_reg(FDSR_OFF_POLARITY, 8'h00);
        check("pol_frozen", 16'h0001, 16'(pol));
        rd_reg(FDSR_OFF_POLARITY, d0, d1);
        check("pol_reg", 16'h0040, d0);
        act = 1'b0;
        wr_reg(FDSR_OFF_POLARITY, 8'h00);
        check("pol_clear", 16'h0000, 16'(pol));
    endtask : test_polarity

    initial begin
        rst = 1'b1;
        act = 1'b0;
        evt1 = '0;
        evt2 = '0;
        mon = '0;
        tgt = 11'd1000;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        check("pol_reset", 16'h0000, 16'(pol));
        check("code_reset", 16'h007f, 16'(last_code));
        check("current_reset", 16'(tgt), 16'(led_cur));
        test_ident();
        test_flags(8'ha5, 5'h1a);
        test_flags(8'h5a, 5'h05);
        test_code(7'h3f);
        test_code(7'h00);
        tgt = 11'h7ff;
        test_code(7'h7f);
        test_polarity();
        wrap_up();
    end
endmodule : fdsr_status_regs_test
